/* ldx_pkg.sv */
// Shared constants, field layout and status assembly for the LED driver serial logic
package ldx_pkg;

  // ----------------------------------------------------------------
  // Word geometry
  // ----------------------------------------------------------------
  localparam int WORD_W = 36;          // Both serial words are this long
  localparam int NOUT = 8;             // Outputs per bank
  localparam int PWM_W = 10;           // PWM value and counter width

  // ----------------------------------------------------------------
  // Control word fields (index = position - 1)
  // ----------------------------------------------------------------
  localparam int ADDR_LSB = 0;
  localparam int ADDR_W = 3;
  localparam int PWM_A_LSB = 3;
  localparam int PWM_B_LSB = 13;
  localparam int WD_DIS_BIT = 23;
  localparam int DIV_LSB = 24;
  localparam int DIV_W = 4;
  localparam int DAC_A_LSB = 28;
  localparam int DAC_B_LSB = 32;
  localparam int DAC_W = 4;

  // ----------------------------------------------------------------
  // Status word fields
  // ----------------------------------------------------------------
  localparam int RAW_W = 18;           // Open flags A/B, watchdog, thermal
  localparam int ST_WD_BIT = 16;
  localparam int ST_THERM_BIT = 17;
  localparam int REV_W = 3;
  localparam int FILL_LSB = 21;
  localparam int FILL_W = 15;
  localparam logic [14:0] FILL_PATTERN = 15'h2AAA; // Odd positions 1, even 0

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int WD_MIN_US = 25;       // Shortest allowed timeout
  localparam int WD_MAX_US = 200;      // Longest allowed timeout
  localparam int WD_CNT_W = 10;
  localparam logic [9:0] WD_CYCLES = 10'((WD_MIN_US * CLK_HZ + 999_999) / 1_000_000);

  // Status word: filler, mask revision, then the raw flags at the bottom
  function automatic logic [WORD_W-1:0] build_status(input logic [RAW_W-1:0] raw,
                                                     input logic [REV_W-1:0] rev);
    return {FILL_PATTERN, rev, raw};
  endfunction : build_status

endpackage : ldx_pkg

/* ldx_link_if.sv */
// Bundle between the shift-clock logic and the system-clock core
`timescale 1ns/1ps
interface ldx_link_if;
  logic [35:0] ctrl_word;  // Last transferred control word (link domain)
  logic xfer_tog;          // Toggles once per transfer
  logic act_tog;           // Toggles on every shift clock rise
  logic [15:0] pwm_on;     // PWM compare results, bank B above bank A
  logic [17:0] st_raw;     // Raw status flags from pins and core

  modport link (input st_raw, output ctrl_word, xfer_tog, act_tog, pwm_on);
  modport core (output st_raw, input ctrl_word, xfer_tog, act_tog, pwm_on);
endinterface : ldx_link_if

/* ldx_sync.sv */
// Two-stage level synchroniser of configurable width
`timescale 1ns/1ps
module ldx_sync #(
  parameter int W = 1
) (
  // Destination clock
  input wire logic clk,
  // Level in and synchronised level out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] s1;  // Metastable stage, read only by s2
    logic [W-1:0] s2;  // Settled stage
  } ldx_sync_type;

  ldx_sync_type st;
  ldx_sync_type next_st;

  // Shift the level through both stages
  always_comb begin
    next_st = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  // Register the stages
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign q = st.s2;

endmodule : ldx_sync

/* ldx_link.sv */
// Shift-clock domain: shift register, transfer, control registers and PWM
`timescale 1ns/1ps
module ldx_link #(
  parameter logic [2:0] MASK_REV = 3'h1
) (
  // Link clock and raw core reset
  input wire logic serial_shift_clock,
  input wire logic srst,
  // Serial pins
  input wire logic transfer_strobe,
  input wire logic serial_data_in,
  output logic serial_data_out,
  // Core side
  ldx_link_if.link lnk
);
  import ldx_pkg::*;

  // ----------------------------------------------------------------
  // State on each edge of the shift clock
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [35:0] sr;       // Shift register
    logic seen_tog;        // Last transfer already answered with status
    logic act_tog;         // Activity indicator for the watchdog
    logic [3:0] pre;       // PWM clock prescaler
    logic [9:0] cnt;       // Free-running PWM counter
    logic [15:0] pwm_on;   // Registered compare results
  } ldx_rise_type;

  typedef struct packed {
    logic xfer_tog;        // Toggles on every transfer
    logic load_q;          // Strobe seen at the previous fall
    logic [35:0] word;     // Parallel control word
    logic [7:0][9:0] val_a;
    logic [7:0][9:0] val_b;
  } ldx_fall_type;

  ldx_rise_type r;
  ldx_rise_type next_r;
  ldx_fall_type n;
  ldx_fall_type next_n;
  logic rst_l;             // Core reset seen on this clock
  logic [17:0] st_q;       // Status flags on this clock
  logic [15:0] pwm_cmp;    // Combinational compare results
  logic [35:0] status_word;

  // Reset and status flags cross in through two flops each
  ldx_sync #(.W(1)) u_rst_sync (.clk(serial_shift_clock), .d(srst), .q(rst_l));
  ldx_sync #(.W(18)) u_st_sync (.clk(serial_shift_clock), .d(lnk.st_raw), .q(st_q));

  assign status_word = build_status(st_q, MASK_REV);

  // Output off whenever the count is above the stored value
  for (genvar g = 0; g < NOUT; g++) begin : g_cmp
    assign pwm_cmp[g] = r.cnt <= n.val_a[g];
    assign pwm_cmp[g + NOUT] = r.cnt <= n.val_b[g];
  end

  // Rising edge: shift, status load, prescaler and PWM counter
  always_comb begin
    next_r = r;
    next_r.act_tog = ~r.act_tog;
    if (!transfer_strobe) begin
      next_r.sr = {r.sr[WORD_W-2:0], serial_data_in};
      next_r.seen_tog = n.xfer_tog;
    end else if (n.xfer_tog != r.seen_tog) begin
      next_r.sr = status_word;
      next_r.seen_tog = n.xfer_tog;
    end
    // PWM clock is the shift clock divided by divisor code plus one
    if (r.pre == n.word[DIV_LSB +: DIV_W]) begin
      next_r.pre = '0;
      next_r.cnt = 10'(r.cnt + 10'h001);
    end else begin
      next_r.pre = 4'(r.pre + 4'h1);
    end
    next_r.pwm_on = pwm_cmp;
    if (rst_l) begin
      next_r = '0;
    end
  end

  always_ff @(posedge serial_shift_clock) begin
    r <= next_r;
  end

  // Falling edge: first fall with strobe high copies the word in
  always_comb begin
    next_n = n;
    next_n.load_q = transfer_strobe;
    if (transfer_strobe && !n.load_q) begin
      next_n.word = r.sr;
      next_n.xfer_tog = ~n.xfer_tog;
      next_n.val_a[r.sr[ADDR_LSB +: ADDR_W]] = r.sr[PWM_A_LSB +: PWM_W];
      next_n.val_b[r.sr[ADDR_LSB +: ADDR_W]] = r.sr[PWM_B_LSB +: PWM_W];
    end
    if (rst_l) begin
      next_n = '0;
    end
  end

  always_ff @(negedge serial_shift_clock) begin
    n <= next_n;
  end

  assign serial_data_out = r.sr[WORD_W-1];
  assign lnk.ctrl_word = n.word;
  assign lnk.xfer_tog = n.xfer_tog;
  assign lnk.act_tog = r.act_tog;
  assign lnk.pwm_on = r.pwm_on;

  // ----------------------------------------------------------------
  // Checks on the link clock
  // ----------------------------------------------------------------
  sequence xfer_fall_s;
    transfer_strobe && !n.load_q;
  endsequence

  shift_in_a: assert property (@(posedge serial_shift_clock) disable iff (rst_l)
    !transfer_strobe |=> r.sr == {$past(r.sr[WORD_W-2:0]), $past(serial_data_in)})
    else $error("shift register did not shift");
  status_load_a: assert property (@(posedge serial_shift_clock) disable iff (rst_l)
    transfer_strobe && n.xfer_tog != r.seen_tog |=>
      r.sr == build_status($past(st_q), MASK_REV) && r.sr[FILL_LSB +: FILL_W] == FILL_PATTERN)
    else $error("status word not loaded after transfer");
  word_copy_a: assert property (@(negedge serial_shift_clock) disable iff (rst_l)
    xfer_fall_s |=> n.word == $past(r.sr) &&
      n.val_a[$past(r.sr[ADDR_LSB +: ADDR_W])] == $past(r.sr[PWM_A_LSB +: PWM_W]))
    else $error("control word not transferred");
  pwm_off_a: assert property (@(posedge serial_shift_clock) disable iff (rst_l)
    r.cnt > n.val_b[0] |=> !r.pwm_on[NOUT])
    else $error("pwm on above stored value");

endmodule : ldx_link

/* ldx_top.sv */
// LED driver serial control and status word logic with watchdog and output gating
`timescale 1ns/1ps
module ldx_top #(
  parameter logic [2:0] MASK_REV = 3'h1 // Arbitrary value
) (
  // System clock and reset
  input wire logic clk,
  input wire logic srst,
  // Serial link
  input wire logic serial_shift_clock,
  input wire logic transfer_strobe,
  input wire logic serial_data_in,
  output logic serial_data_out,
  // Output health (1 = output normal) and temperature sense (1 = overtemperature)
  input wire logic [ldx_pkg::NOUT-1:0] open_ok_a,
  input wire logic [ldx_pkg::NOUT-1:0] open_ok_b,
  input wire logic overtemp,
  // Output drive and coarse current codes
  output logic [ldx_pkg::NOUT-1:0] led_on_a,
  output logic [ldx_pkg::NOUT-1:0] led_on_b,
  output logic [ldx_pkg::DAC_W-1:0] dac_code_a,
  output logic [ldx_pkg::DAC_W-1:0] dac_code_b,
  output logic watchdog_timeout
);
  import ldx_pkg::*;

  // ----------------------------------------------------------------
  // State of the system-clock core
  // ----------------------------------------------------------------
  typedef struct packed {
    logic xfer_prev;              // Last seen transfer toggle
    logic act_prev;               // Last seen activity toggle
    logic valid;                  // A word has arrived since reset
    logic wd_dis;                 // Watchdog disabled by the word
    logic wd_flag;                // Watchdog timed out
    logic [9:0] wd_cnt;           // Cycles since last shift clock rise
    logic [3:0] dac_a;            // Coarse code, bank A
    logic [3:0] dac_b;            // Coarse code, bank B
    logic [7:0] led_a;            // Gated drive, bank A
    logic [7:0] led_b;            // Gated drive, bank B
  } ldx_core_type;

  ldx_core_type st;               // Registered state
  ldx_core_type next_st;          // Next state
  ldx_link_if lnk ();             // Bundle to the link logic
  logic [1:0] tog_q;              // Transfer and activity toggles, synced
  logic [15:0] pwm_q;             // PWM compare results, synced
  logic therm_q;                  // Overtemperature, synced
  logic xfer_evt;                 // One-cycle pulse per transfer
  logic act_evt;                  // One-cycle pulse per shift clock rise
  logic wd_expire;                // Counter reached the timeout
  logic drive_ok;                 // Outputs may follow their PWM

  // ----------------------------------------------------------------
  // Clock domains
  // ----------------------------------------------------------------
  // The link logic runs only while the controller clocks it, so what
  // must act without a shift clock lives here: the watchdog, the
  // output gating and the coarse codes.
  // The link reports to the core through two toggles, one per shift
  // clock rise and one per transfer. A toggle level lasts a whole
  // shift clock period, four core cycles at the bench rate, so no
  // change is lost; a controller clocking faster than half the core
  // clock may hide activity and is not supported.
  // The control word crosses without synchronisers: it is read only
  // after the transfer toggle has settled, and it cannot change
  // again before 36 more shift clocks, far longer than the crossing.

  // ----------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------

  // Raw status flags; the link logic brings them into its own domain
  // Open flags pass straight through: 0 marks an open output
  assign lnk.st_raw = {overtemp, st.wd_flag, open_ok_b, open_ok_a};

  // Shift register, transfer and PWM all run on the shift clock
  ldx_link #(.MASK_REV(MASK_REV)) u_link (
    .serial_shift_clock(serial_shift_clock),
    .srst(srst),
    .transfer_strobe(transfer_strobe),
    .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out),
    .lnk(lnk)
  );

  // ----------------------------------------------------------------
  // Crossings into the system clock
  // ----------------------------------------------------------------

  // Toggles are events; the word itself is sampled only after the
  // transfer toggle has settled, and it holds for a whole word time
  ldx_sync #(.W(2)) u_tog_sync (
    .clk(clk),
    .d({lnk.act_tog, lnk.xfer_tog}),
    .q(tog_q)
  );

  // PWM levels may glitch by one sample; outputs lag the link by
  // three system clocks, well under one PWM step
  ldx_sync #(.W(16)) u_pwm_sync (
    .clk(clk),
    .d(lnk.pwm_on),
    .q(pwm_q)
  );

  // Temperature sense pin
  ldx_sync #(.W(1)) u_therm_sync (
    .clk(clk),
    .d(overtemp),
    .q(therm_q)
  );

  // Edge detection on the settled stages only
  assign xfer_evt = tog_q[0] != st.xfer_prev;
  assign act_evt = tog_q[1] != st.act_prev;

  // The limit is the shortest allowed idle time in core cycles. The
  // toggle crossing adds two or three cycles on top, so the flag can
  // never come early; the upper limit is met with a wide margin, which
  // matters because the controller cannot see how long its own clock
  // gaps really are.
  // Timeout only counts while the watchdog is armed
  assign wd_expire = (st.wd_cnt == WD_CYCLES) && !st.wd_dis;

  // A watchdog timeout, overtemperature or no word since reset holds every output off
  assign drive_ok = st.valid && !st.wd_flag && !therm_q;

  // ----------------------------------------------------------------
  // Core next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.xfer_prev = tog_q[0];
    next_st.act_prev = tog_q[1];

    // Idle counter restarts on every shift clock rise and saturates
    if (act_evt) begin
      next_st.wd_cnt = '0;
    end else if (st.wd_cnt != WD_CYCLES) begin
      next_st.wd_cnt = 10'(st.wd_cnt + 10'h001);
    end

    // New word: pick up the watchdog enable and the coarse codes
    // A fresh word also clears a timeout: the controller is back
    if (xfer_evt) begin
      next_st.valid = 1'b1;
      next_st.wd_dis = lnk.ctrl_word[WD_DIS_BIT];
      next_st.dac_a = lnk.ctrl_word[DAC_A_LSB +: DAC_W];
      next_st.dac_b = lnk.ctrl_word[DAC_B_LSB +: DAC_W];
      next_st.wd_flag = 1'b0;
    end

    // Timeout sets the flag; a set in the clearing cycle still wins
    if (wd_expire) begin
      next_st.wd_flag = 1'b1;
    end

    // Thermal shutdown uses the core's own copy of the pin, so it
    // still acts while the shift clock is stopped
    // Gate the PWM onto the outputs
    if (drive_ok) begin
      next_st.led_a = pwm_q[NOUT-1:0];
      next_st.led_b = pwm_q[2*NOUT-1:NOUT];
    end else begin
      next_st.led_a = '0;
      next_st.led_b = '0;
    end

    // Reset clears everything, outputs off
    if (srst) begin
      next_st = '0;
    end
  end

  // Register the core state; one flop bank holds every field
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign led_on_a = st.led_a;
  assign led_on_b = st.led_b;
  assign dac_code_a = st.dac_a;
  assign dac_code_b = st.dac_b;
  assign watchdog_timeout = st.wd_flag;

  // ----------------------------------------------------------------
  // Checks on the system clock
  // ----------------------------------------------------------------
  // All checks below run on the core clock and rest during reset
  default clocking core_cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // Bound on the idle time before the flag rises
  // The helper count runs from the core's view of the last shift
  // clock rise and saturates, so a long gap with the watchdog
  // disabled cannot wrap it
  localparam int WD_LATE = 4980;
  logic [12:0] idle_cnt;          // Cycles since last seen activity
  always_ff @(posedge clk) begin
    if (srst || act_evt) begin
      idle_cnt <= '0;
    end else if (idle_cnt != 13'h1FFF) begin
      idle_cnt <= 13'(idle_cnt + 13'h0001);
    end
  end

  sequence expire_s;
    wd_expire;
  endsequence

  sequence all_off_s;
    led_on_a == '0 && led_on_b == '0;
  endsequence

  // A transfer has just been seen
  sequence word_seen_s;
    xfer_evt;
  endsequence

  // A shift clock rise has just been seen
  sequence link_active_s;
    act_evt;
  endsequence

  wd_set_a: assert property (expire_s |=> st.wd_flag)
    else $error("watchdog flag not set on expiry");
  wd_early_a: assert property ($rose(st.wd_flag) |-> $past(st.wd_cnt) == WD_CYCLES)
    else $error("watchdog flag set too early");
  wd_late_a: assert property (!st.wd_dis && !st.wd_flag |-> idle_cnt < WD_LATE)
    else $error("watchdog flag set too late");
  wd_disable_a: assert property ($rose(st.wd_flag) |-> !$past(st.wd_dis))
    else $error("disabled watchdog timed out");
  wd_off_a: assert property (st.wd_flag |=> all_off_s)
    else $error("outputs on during watchdog timeout");
  reset_off_a: assert property (!st.valid |=> all_off_s)
    else $error("outputs on before first word");
  pwm_follow_a: assert property (drive_ok |=> led_on_a == $past(pwm_q[NOUT-1:0]))
    else $error("output does not follow pwm");
  dac_take_a: assert property (xfer_evt |=>
      dac_code_b == $past(lnk.ctrl_word[DAC_B_LSB +: DAC_W]))
    else $error("coarse code not taken");
  therm_off_a: assert property (therm_q |=> all_off_s)
    else $error("outputs on during overtemperature");

  // The flag never rises before the idle time has passed the limit
  wd_min_a: assert property ($rose(st.wd_flag) |-> idle_cnt > WD_CYCLES)
    else $error("watchdog flag set before the idle limit");
  // Every shift clock rise restarts the idle count
  wd_restart_a: assert property (link_active_s |=> st.wd_cnt == '0)
    else $error("idle count not restarted by shift clock");
  // The flag stays up until a new word arrives
  wd_hold_a: assert property (st.wd_flag && !xfer_evt |=> watchdog_timeout)
    else $error("watchdog flag dropped without a transfer");
  // A new word clears the flag unless the timeout fires again
  wd_clear_a: assert property (xfer_evt && !wd_expire |=> !watchdog_timeout)
    else $error("watchdog flag not cleared by a transfer");
  // The word's watchdog bit is taken with the transfer
  wd_dis_take_a: assert property (word_seen_s |=>
      st.wd_dis == $past(lnk.ctrl_word[WD_DIS_BIT]))
    else $error("watchdog enable not taken");
  // Bank A coarse code is taken with the transfer
  dac_a_take_a: assert property (word_seen_s |=>
      dac_code_a == $past(lnk.ctrl_word[DAC_A_LSB +: DAC_W]))
    else $error("coarse code of bank A not taken");
  // Coarse codes hold between transfers
  dac_hold_a: assert property (!xfer_evt |=>
      $stable(dac_code_a) && $stable(dac_code_b))
    else $error("coarse code changed without a transfer");
  // Bank B outputs follow their PWM like bank A
  pwm_follow_b_a: assert property (drive_ok |=>
      led_on_b == $past(pwm_q[2*NOUT-1:NOUT]))
    else $error("bank B output does not follow pwm");
  // A transfer marks the control registers as loaded
  valid_set_a: assert property (word_seen_s |=> st.valid)
    else $error("first word not taken");
  // Once loaded, the registers stay loaded until reset
  valid_hold_a: assert property (st.valid |=> st.valid)
    else $error("loaded state lost without reset");

endmodule : ldx_top

/* ldx_ctrl_model.sv */
// Display controller model driving the serial shift interface of the LED driver
`timescale 1ns/1ps
module ldx_ctrl_model (
  // Link pins driven by the controller
  output logic serial_shift_clock,
  output logic transfer_strobe,
  output logic serial_data_in,
  // Link pin returned by the driver
  input wire logic serial_data_out
);
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int HALF = 80; // Half of the 160 ns link period, well inside the idle limit

  // Clock stands still low outside frames
  initial begin
    serial_shift_clock = 1'b0;
    transfer_strobe = 1'b0;
    serial_data_in = 1'b0;
  end

  // Bare clock pulses with strobe low, used while the link logic is in reset
  task pulse(input int n);
    repeat (n) begin
      #HALF serial_shift_clock = 1'b1;
      #HALF serial_shift_clock = 1'b0;
    end
  endtask : pulse

  // One whole frame: 36 bits in, then the transfer; returns what shifted out
  task xfer(input logic [35:0] w, output logic [35:0] st);
    #23;
    for (int i = 35; i >= 0; i--) begin
      st[i] = serial_data_out; // Out bit is settled since the previous rise
      serial_data_in = w[i];
      #HALF serial_shift_clock = 1'b1;
      #HALF serial_shift_clock = 1'b0;
    end
    // Line no longer carries data, so it shows the inverse to expose stale sampling;
    // the strobe rises clear of the last fall so that fall cannot see it
    #23;
    serial_data_in = ~serial_data_in;
    transfer_strobe = 1'b1;
    #HALF serial_shift_clock = 1'b1; // Refused rise: no shifting
    #HALF serial_shift_clock = 1'b0; // Fall copies the word
    #HALF serial_shift_clock = 1'b1; // Rise loads the status word
    #HALF serial_shift_clock = 1'b0; // Second fall must do nothing
    #HALF transfer_strobe = 1'b0;
  endtask : xfer
endmodule : ldx_ctrl_model

/* ldx_testbench.sv */
// Self-checking testbench for the LED driver serial control and status logic
`timescale 1ns/1ps
module testbench;
  import ldx_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [2:0] REV = 3'h5; // Arbitrary value
  logic clk, srst, overtemp, sck, strobe, sdi, sdo, wd;
  logic [7:0] open_ok_a, open_ok_b, led_on_a, led_on_b;
  logic [3:0] dac_code_a, dac_code_b;
  logic [35:0] st;
  int failures, total_checks;

  ldx_top #(.MASK_REV(REV)) dut_u (
    .clk(clk), .srst(srst), .serial_shift_clock(sck), .transfer_strobe(strobe),
    .serial_data_in(sdi), .serial_data_out(sdo), .open_ok_a(open_ok_a),
    .open_ok_b(open_ok_b), .overtemp(overtemp), .led_on_a(led_on_a), .led_on_b(led_on_b),
    .dac_code_a(dac_code_a), .dac_code_b(dac_code_b), .watchdog_timeout(wd)
  );
  ldx_ctrl_model ctrl_u (
    .serial_shift_clock(sck), .transfer_strobe(strobe), .serial_data_in(sdi),
    .serial_data_out(sdo)
  );

  // 25 MHz system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Control word, fields packed from position 36 down to position 1
  function automatic logic [35:0] mk(input logic [2:0] ad, input logic [9:0] pa,
    input logic [9:0] pb, input logic dis, input logic [3:0] dv, input logic [3:0] da,
    input logic [3:0] db);
    return {db, da, dv, dis, pb, pa, ad};
  endfunction : mk

  // Expected status: filler, revision, thermal, watchdog, bank B, bank A
  function automatic logic [35:0] stx(input logic [7:0] a, input logic [7:0] b,
    input logic w, input logic t);
    return {15'h2AAA, REV, t, w, b, a};
  endfunction : stx

  task check(input logic [35:0] seen, input logic [35:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Wait n system clocks, then step just past the edge
  task clks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : clks

  task conclude();
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude

  // Hang guard, far beyond the expected run of about 150 us
  initial begin
    #1_000_000;
    failures++;
    $display("mismatch at %0t: run did not finish", $time);
    conclude();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    failures = 0;
    total_checks = 0;
    srst = 1'b1;
    overtemp = 1'b0;
    open_ok_a = 8'hFF;
    open_ok_b = 8'hFF;
    // Link logic needs shift clock rises during reset, so reset lasts a little longer
    clks(6);
    ctrl_u.pulse(4);
    clks(1);
    srst = 1'b0;
    // Link logic leaves reset only after two more shift clock rises
    ctrl_u.pulse(3);
    clks(4);
    check(36'({led_on_a, led_on_b, dac_code_a, dac_code_b, wd}), 36'h0);
    $display("test reset done");

    // Every address, with status read back one frame later
    open_ok_a = 8'h5A;
    open_ok_b = 8'hC3;
    for (int k = 0; k < 8; k++) begin
      ctrl_u.xfer(mk(3'(k), 10'h3FF, 10'h000, 1'b1, 4'hF, 4'(k), 4'(~k)), st);
      clks(10);
      if (k > 0) check(st, stx(8'h5A, 8'hC3, 1'b0, 1'b0));
      check(36'({dac_code_a, dac_code_b}), 36'({4'(k), 4'(~k)}));
    end
    check(36'({led_on_a, led_on_b}), 36'h0FF00);
    // Stored zero with a running count turns output 0 of bank A off; full value turns output 0 of bank B on
    ctrl_u.xfer(mk(3'h0, 10'h000, 10'h3FF, 1'b1, 4'hF, 4'h0, 4'h0), st);
    clks(10);
    check(36'({led_on_a, led_on_b}), 36'h0FE01);
    $display("test addresses done");

    // Disabled watchdog ignores a long idle clock
    clks(750);
    check(36'({wd, led_on_a, led_on_b}), 36'h0FE01);
    // Enabled watchdog: quiet before the lower limit, fired after it
    ctrl_u.xfer(mk(3'h0, 10'h3FF, 10'h000, 1'b0, 4'hF, 4'h0, 4'h0), st);
    clks(590);
    check(36'({wd, led_on_a, led_on_b}), 36'h0FF00);
    clks(150);
    check(36'({wd, led_on_a, led_on_b}), 36'h10000);
    ctrl_u.xfer(mk(3'h0, 10'h3FF, 10'h000, 1'b1, 4'hF, 4'h0, 4'h0), st);
    clks(10);
    check(36'({wd, led_on_a, led_on_b}), 36'h0FF00);
    $display("test watchdog done");

    // Overtemperature forces outputs off and shows in the status
    overtemp = 1'b1;
    open_ok_a = 8'hFF;
    open_ok_b = 8'h00;
    clks(5);
    ctrl_u.xfer(mk(3'h1, 10'h3FF, 10'h000, 1'b1, 4'hF, 4'h3, 4'hC), st);
    clks(10);
    check(36'({led_on_a, led_on_b}), 36'h0);
    check(st, stx(8'h5A, 8'hC3, 1'b1, 1'b0));
    ctrl_u.xfer(mk(3'h1, 10'h3FF, 10'h000, 1'b1, 4'hF, 4'h3, 4'hC), st);
    check(st, stx(8'hFF, 8'h00, 1'b0, 1'b1));
    $display("test thermal done");
    conclude();
  end
endmodule : testbench
